/* File: ubg_pkg.sv */
package ubg_pkg;
  // register offsets on the byte-wide register port
  localparam logic [2:0] REG_DATA     = 3'h0;
  localparam logic [2:0] REG_DIV_HIGH = 3'h1;
  localparam logic [2:0] REG_DIV_LOW  = 3'h2;
  localparam logic [2:0] REG_FIFO_CTL = 3'h3;
  localparam logic [2:0] REG_FILL_CNT = 3'h4;
  localparam logic [2:0] REG_CONTROL  = 3'h5;
  localparam logic [2:0] REG_STATUS   = 3'h6;
  // fifo_baud_control field positions
  localparam int FCTL_THR_LSB   = 0;
  localparam int FCTL_RANGE_BIT = 2;
  localparam int FCTL_FRAC_LSB  = 3;
  localparam int FCTL_WIDTH     = 6;
  // control register field positions
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_RXIE_BIT   = 1;
  // status register field positions
  localparam int STAT_AVAIL_BIT   = 0;
  localparam int STAT_OVERRUN_BIT = 1;
  localparam int STAT_HOLD_BIT    = 2;
  localparam int STAT_DIVLOW_BIT  = 3;
  // values after reset
  localparam logic [7:0] DIV_HIGH_RESET = 8'h00;
  localparam logic [7:0] DIV_LOW_RESET  = 8'h00;
  localparam logic [5:0] FIFO_CTL_RESET = 6'h00;
  // smallest divisor per range selection
  localparam logic [15:0] DIV_MIN_NORMAL = 16'h0010;
  localparam logic [15:0] DIV_MIN_FAST   = 16'h0008;
  // receive queue geometry and frame size
  localparam int          RX_FIFO_DEPTH  = 4;
  localparam int          FILL_CNT_WIDTH = 3;
  localparam logic [2:0]  LAST_DATA_BIT  = 3'h7;
  localparam logic [2:0]  THR_FULL_BYTES = 3'h4;
  // receiver states, gray coded along idle-start-data-stop
  typedef enum logic [1:0] {
    RX_IDLE  = 2'h0,
    RX_START = 2'h1,
    RX_DATA  = 2'h3,
    RX_STOP  = 2'h2
  } ubg_rx_state_t;
endpackage : ubg_pkg

/* File: ubg_fifo_if.sv */
`timescale 1ns/1ps
interface ubg_fifo_if #(
  parameter int WIDTH = 8,
  parameter int CW    = 3
);
  logic             inValid;   // producer offers a word
  logic             inReady;   // queue has room
  logic [WIDTH-1:0] inData;    // word offered
  logic             outValid;  // queue holds a word
  logic             outReady;  // consumer takes the head word
  logic [WIDTH-1:0] outData;   // head word, registered
  logic [CW-1:0]    count;     // words held
  logic             flush;     // empty the queue
  // the queue itself
  modport store (input inValid, inData, outReady, flush,
                 output inReady, outValid, outData, count);
  // the logic that fills and drains it
  modport user  (output inValid, inData, outReady, flush,
                 input inReady, outValid, outData, count);
endinterface : ubg_fifo_if

/* File: ubg_fifo.sv */
`timescale 1ns/1ps
module ubg_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int CW    = 6
) (
  // clock and reset
  input wire logic   clk_sys,
  input wire logic   rst,
  // queue port
  ubg_fifo_if.store  port
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // pointer wrap relies on a power-of-two depth
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || CW < $clog2(DEPTH + 1)) begin : g_chk
    $error("ubg_fifo: depth must be a power of two and count wide enough");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;   // storage words
    logic [AW-1:0]               wrPtr; // next slot to fill
    logic [AW-1:0]               rdPtr; // head slot
    logic [CW-1:0]               count; // words held
    logic [WIDTH-1:0]            head;  // registered head word
  } ubg_fifo_state_t;

  ubg_fifo_state_t s_q, s_d;
  logic            push;
  logic            pop;

  assign port.inReady  = (s_q.count < DEPTH);
  assign port.outValid = (s_q.count != '0);
  assign port.outData  = s_q.head;
  assign port.count    = s_q.count;

  // next state; head is read after the write so a fresh word shows at once
  always_comb begin
    s_d  = s_q;
    push = port.inValid && (s_q.count < DEPTH);
    pop  = port.outReady && (s_q.count != '0);
    if (push) begin
      s_d.mem[s_q.wrPtr] = port.inData;
      s_d.wrPtr          = s_q.wrPtr + 1'b1;
    end
    if (pop) begin
      s_d.rdPtr = s_q.rdPtr + 1'b1;
    end
    if (push && !pop) begin
      s_d.count = s_q.count + 1'b1;
    end else if (pop && !push) begin
      s_d.count = s_q.count - 1'b1;
    end
    if (port.flush) begin
      s_d.wrPtr = '0;
      s_d.rdPtr = '0;
      s_d.count = '0;
    end
    s_d.head = s_d.mem[s_d.rdPtr];
  end

  // state register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : ubg_fifo

/* File: ubg_baud_gen.sv */
`timescale 1ns/1ps
module ubg_baud_gen (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // timing control
  input  wire logic        restart,
  input  wire logic [15:0] divisor,
  input  wire logic [2:0]  frac,
  input  wire logic        rangeSel,
  // timing strobes
  output logic             samplePulse,
  output logic [1:0]       sampleIdx,
  output logic             bitEnd
);
  typedef struct packed {
    logic [15:0] cnt;  // cycles into the current bit time
    logic [3:0]  acc;  // fraction accumulator, wraps
    logic        ext;  // current bit time lengthened by one cycle
  } ubg_baud_state_t;

  ubg_baud_state_t s_q, s_d;
  logic [16:0]     lastCnt;
  logic [15:0]     half;
  logic [15:0]     pt0;
  logic [15:0]     pt1;
  logic [15:0]     pt2;
  logic [3:0]      low3Sum;

  // bit time end and the three sampling points
  always_comb begin
    lastCnt     = {1'b0, divisor} + {16'h0000, s_q.ext} - 17'h00001;
    bitEnd      = ({1'b0, s_q.cnt} == lastCnt);
    half        = {1'b0, divisor[15:1]};
    pt0         = rangeSel ? half - 16'h0001 : half;
    pt1         = rangeSel ? half : half + 16'h0001;
    pt2         = half + 16'h0002;
    samplePulse = (s_q.cnt == pt0) || (s_q.cnt == pt1) || (s_q.cnt == pt2);
    sampleIdx   = (s_q.cnt == pt0) ? 2'h0 : (s_q.cnt == pt1) ? 2'h1 : 2'h2;
  end

  // free-running timer, realigned by the receiver on a start edge
  always_comb begin
    s_d     = s_q;
    low3Sum = {1'b0, s_q.acc[2:0]} + {1'b0, frac};
    if (restart) begin
      s_d.cnt = 16'h0000;
      s_d.acc = {1'b0, frac};
      s_d.ext = 1'b0;
    end else if (bitEnd) begin
      s_d.cnt = 16'h0000;
      s_d.acc = s_q.acc + {1'b0, frac};
      s_d.ext = low3Sum[3];
    end else begin
      s_d.cnt = s_q.cnt + 16'h0001;
    end
  end

  // state register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : ubg_baud_gen

/* File: ubg_top.sv */
// How it works
// - one byte data register, write sends, read receives
// - bit time is divisor plus fraction eighths
// - divisor floor sixteen, or eight when fast range; a lower divisor is only flagged in status
// - fraction accumulator carry stretches a bit one cycle
// - three samples per bit around half divisor
// - threshold code picks bytes needed for available flag
// - available flag with enable raises the interrupt request
// - queue empty and count zero after reset
// - fill count follows bytes in and reads out
// - full queue: extra byte waits, next overwrites it
// - fill count cleared by reset or disable, read-only
// - generator built on a free-running sixteen-bit timer
// - unused upper bits of control and count read zero
// - disable empties buffers, keeps control bits
`timescale 1ns/1ps
module ubg_top
  import ubg_pkg::*;
#(
  parameter int RX_DEPTH = RX_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // register port
  input  wire logic [2:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  output logic      [7:0] regRdData,
  // serial receive line
  input  wire logic       rxLine,
  // byte handed to the transmitter
  output logic      [7:0] txData,
  output logic            txStrobe,
  // status toward the rest of the chip
  output logic            rxAvailable,
  output logic            uartIrq,
  output logic            rxOverrun
);

  // the fill count is three bits wide, so the queue cannot grow past seven
  if (RX_DEPTH < 2 || RX_DEPTH > 7 || (RX_DEPTH & (RX_DEPTH - 1)) != 0) begin : g_chk
    $error("ubg_top: receive depth must be 2 or 4");
  end

  // state of the block outside the receive queue and the baud timer
  typedef struct packed {
    logic [7:0]            divHigh;     // baud_divisor_high
    logic [7:0]            divLow;      // baud_divisor_low
    logic [FCTL_WIDTH-1:0] fifoCtl;     // fifo_baud_control, six live bits
    logic                  enable;      // uart_master_enable
    logic                  rxIe;        // rx_irq_enable
    ubg_rx_state_t         rxState;     // receiver sequence
    logic [2:0]            bitCnt;      // data bit being received
    logic [7:0]            shifter;     // receive shift register
    logic [2:0]            votes;       // the three line samples of a bit
    logic                  lineLast;    // line level one cycle ago
    logic [7:0]            hold;        // byte waiting for queue room
    logic                  holdValid;   // hold carries a byte
    logic                  overrun;     // overrun_flag
    logic                  availFlag;   // rx_available_flag
    logic                  irq;         // interrupt request
    logic [7:0]            rdData;      // read data, valid one cycle
    logic [7:0]            txData;      // last byte written for sending
    logic                  txStrobe;    // one-cycle hand-off pulse
  } ubg_top_state_t;

  // reset image; receiver idle with the line assumed high
  localparam ubg_top_state_t TOP_RESET = '{
    divHigh:   DIV_HIGH_RESET,
    divLow:    DIV_LOW_RESET,
    fifoCtl:   FIFO_CTL_RESET,
    enable:    1'b0,
    rxIe:      1'b0,
    rxState:   RX_IDLE,
    bitCnt:    3'h0,
    shifter:   8'h00,
    votes:     3'h0,
    lineLast:  1'b1,
    hold:      8'h00,
    holdValid: 1'b0,
    overrun:   1'b0,
    availFlag: 1'b0,
    irq:       1'b0,
    rdData:    8'h00,
    txData:    8'h00,
    txStrobe:  1'b0
  };

  ubg_top_state_t s_q, s_d;

  // receive queue between the receiver hold byte and software reads
  ubg_fifo_if #(.WIDTH(8), .CW(FILL_CNT_WIDTH)) rxq ();

  // baud timing strobes
  logic        restart;      // realign bit timing to a start edge
  logic        samplePulse;  // a sampling point in this cycle
  logic [1:0]  sampleIdx;    // which of the three points
  logic        bitEnd;       // last cycle of a bit time
  logic        bitVal;       // majority of the three samples
  logic        gotByte;      // a frame finished with a good stop bit
  logic [15:0] divisor;      // assembled baud divisor
  logic        divisorLow;   // divisor below the floor of its range

  // majority vote over three samples
  function automatic logic maj3(input logic [2:0] v);
    maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction : maj3

  // bytes needed before the available flag rises
  function automatic logic [2:0] fillThreshold(input logic [1:0] code);
    fillThreshold = (code == 2'h0) ? THR_FULL_BYTES : {1'b0, code};
  endfunction : fillThreshold

  // divisor is the high byte over the low byte
  assign divisor = {s_q.divHigh, s_q.divLow};

  // too-small divisors only show in status; hardware still runs with them
  assign divisorLow = s_q.fifoCtl[FCTL_RANGE_BIT] ? (divisor < DIV_MIN_FAST)
                                                  : (divisor < DIV_MIN_NORMAL);

  ubg_baud_gen u_baud (
    .clk_sys     (clk_sys),
    .rst         (rst),
    .restart     (restart),
    .divisor     (divisor),
    .frac        (s_q.fifoCtl[FCTL_FRAC_LSB +: 3]),
    .rangeSel    (s_q.fifoCtl[FCTL_RANGE_BIT]),
    .samplePulse (samplePulse),
    .sampleIdx   (sampleIdx),
    .bitEnd      (bitEnd)
  );

  ubg_fifo #(
    .WIDTH (8),
    .DEPTH (RX_DEPTH),
    .CW    (FILL_CNT_WIDTH)
  ) u_rxq (
    .clk_sys (clk_sys),
    .rst     (rst),
    .port    (rxq)
  );

  // queue hookup: the hold byte is offered until the queue takes it
  assign rxq.inValid  = s_q.holdValid;
  assign rxq.inData   = s_q.hold;
  // a data register read while bytes are queued takes the head byte
  assign rxq.outReady = regRead && (regAddr == REG_DATA) && s_q.enable;
  // disabling the block drops every queued byte
  assign rxq.flush    = !s_q.enable;

  // outputs straight from the state register
  assign regRdData   = s_q.rdData;
  assign txData      = s_q.txData;
  assign txStrobe    = s_q.txStrobe;
  assign rxAvailable = s_q.availFlag;
  assign uartIrq     = s_q.irq;
  assign rxOverrun   = s_q.overrun;

  // next state of the whole block
  always_comb begin
    s_d        = s_q;
    bitVal     = maj3(s_q.votes);
    restart    = 1'b0;
    gotByte    = 1'b0;
    s_d.txStrobe = 1'b0;
    s_d.rdData   = 8'h00;
    s_d.lineLast = rxLine;

    // register writes; count and status ignore writes
    if (regWrite) begin
      case (regAddr)
        REG_DATA: begin
          // only an enabled block passes a byte on for sending
          if (s_q.enable) begin
            s_d.txData   = regWrData;
            s_d.txStrobe = 1'b1;
          end
        end
        REG_DIV_HIGH: s_d.divHigh = regWrData;
        REG_DIV_LOW:  s_d.divLow  = regWrData;
        REG_FIFO_CTL: s_d.fifoCtl = regWrData[FCTL_WIDTH-1:0];
        REG_CONTROL: begin
          s_d.enable = regWrData[CTRL_ENABLE_BIT];
          s_d.rxIe   = regWrData[CTRL_RXIE_BIT];
        end
        REG_FILL_CNT: s_d.rdData = 8'h00;
        default:      s_d.rdData = 8'h00;
      endcase
    end

    // register reads, answered in the next cycle only
    if (regRead) begin
      case (regAddr)
        REG_DATA:     s_d.rdData = rxq.outData;
        REG_DIV_HIGH: s_d.rdData = s_q.divHigh;
        REG_DIV_LOW:  s_d.rdData = s_q.divLow;
        REG_FIFO_CTL: s_d.rdData = {2'h0, s_q.fifoCtl};
        REG_FILL_CNT: s_d.rdData = {5'h00, rxq.count};
        REG_CONTROL:  s_d.rdData = {6'h00, s_q.rxIe, s_q.enable};
        REG_STATUS: begin
          s_d.rdData                   = 8'h00;
          s_d.rdData[STAT_AVAIL_BIT]   = s_q.availFlag;
          s_d.rdData[STAT_OVERRUN_BIT] = s_q.overrun;
          s_d.rdData[STAT_HOLD_BIT]    = s_q.holdValid;
          s_d.rdData[STAT_DIVLOW_BIT]  = divisorLow;
        end
        default:      s_d.rdData = 8'h00;
      endcase
    end

    // collect the three samples of the current bit
    if (samplePulse) begin
      s_d.votes[sampleIdx] = rxLine;
    end

    // receiver sequence
    case (s_q.rxState)
      RX_IDLE: begin
        // a falling line edge starts a frame and realigns the timer
        if (s_q.enable && s_q.lineLast && !rxLine) begin
          restart     = 1'b1;
          s_d.rxState = RX_START;
          s_d.votes   = 3'h0;
        end
      end
      RX_START: begin
        // a start bit that votes high was a glitch
        if (bitEnd) begin
          s_d.rxState = bitVal ? RX_IDLE : RX_DATA;
          s_d.bitCnt  = 3'h0;
        end
      end
      RX_DATA: begin
        // bits arrive least significant first
        if (bitEnd) begin
          s_d.shifter = {bitVal, s_q.shifter[7:1]};
          s_d.bitCnt  = s_q.bitCnt + 3'h1;
          if (s_q.bitCnt == LAST_DATA_BIT) begin
            s_d.rxState = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        // a low stop bit drops the byte; frame errors are not flagged here
        if (bitEnd) begin
          gotByte     = bitVal;
          s_d.rxState = RX_IDLE;
        end
      end
      default: s_d.rxState = RX_IDLE;
    endcase

    // the queue took the hold byte this cycle
    if (s_q.holdValid && rxq.inReady) begin
      s_d.holdValid = 1'b0;
    end

    // a finished byte goes to hold; overwriting a stuck byte is an overrun
    if (gotByte) begin
      if (s_q.holdValid && !rxq.inReady) begin
        s_d.overrun = 1'b1;
      end
      s_d.hold      = s_q.shifter;
      s_d.holdValid = 1'b1;
    end

    // available flag follows the fill level against the chosen threshold;
    // it lags the count by one cycle because the flag is itself registered
    s_d.availFlag = s_q.enable &&
                    (rxq.count >= fillThreshold(s_q.fifoCtl[FCTL_THR_LSB +: 2]));
    // uses the enable being written now, so the request never lags the flag
    s_d.irq       = s_d.availFlag && s_d.rxIe;

    // disabled: drop data and status, keep divisor and control fields
    if (!s_q.enable) begin
      s_d.rxState   = RX_IDLE;
      s_d.holdValid = 1'b0;
      s_d.overrun   = 1'b0;
      s_d.availFlag = 1'b0;
      s_d.irq       = 1'b0;
      s_d.bitCnt    = 3'h0;
    end
  end

  // state register; reset leaves the queue and counts empty
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_q <= TOP_RESET;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : ubg_top

/* File: ubg_properties.sv */
`timescale 1ns/1ps
module ubg_properties
  import ubg_pkg::*;
#(
  parameter int RX_DEPTH = RX_FIFO_DEPTH
) (
  // clock and reset
  input logic       clk_sys,
  input logic       rst,
  // register port
  input logic [2:0] regAddr,
  input logic [7:0] regWrData,
  input logic       regWrite,
  input logic       regRead,
  input logic [7:0] regRdData,
  // serial line and status
  input logic       rxLine,
  input logic [7:0] txData,
  input logic       txStrobe,
  input logic       rxAvailable,
  input logic       uartIrq,
  input logic       rxOverrun
);
  logic       enQ;           // master enable as last written
  logic       ieQ;           // receive irq enable as last written
  logic [7:0] shadowQ [1:3]; // divisor bytes and fifo control as written

  // shadow of the writable settings, so readback is judged without the design
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      enQ     <= 1'b0;
      ieQ     <= 1'b0;
      shadowQ <= '{default: 8'h00};
    end else if (regWrite) begin
      if (regAddr == REG_CONTROL) begin
        enQ <= regWrData[CTRL_ENABLE_BIT];
        ieQ <= regWrData[CTRL_RXIE_BIT];
      end
      if (regAddr == REG_DIV_HIGH || regAddr == REG_DIV_LOW) begin
        shadowQ[regAddr] <= regWrData;
      end
      if (regAddr == REG_FIFO_CTL) begin
        shadowQ[3] <= {2'h0, regWrData[5:0]}; // top two bits are not stored
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // bus steps the properties are built from
  sequence s_data_wr;
    regWrite && regAddr == REG_DATA;
  endsequence
  sequence s_disable_wr;
    regWrite && regAddr == REG_CONTROL && !regWrData[CTRL_ENABLE_BIT];
  endsequence
  sequence s_cfg_rd;
    regRead && (regAddr == REG_DIV_HIGH || regAddr == REG_DIV_LOW || regAddr == REG_FIFO_CTL);
  endsequence

  a_rd_idle_zero: assert property (!regRead |=> regRdData == 8'h00)
    else $error("read data not zero outside a read answer");
  a_cfg_read_back: assert property (s_cfg_rd |=> regRdData == $past(shadowQ[regAddr]))
    else $error("setting register read back wrong");
  a_fill_count_range: assert property (regRead && regAddr == REG_FILL_CNT |=> regRdData <= RX_DEPTH)
    else $error("fill count above depth or upper bits set");
  a_tx_handoff: assert property (s_data_wr ##0 enQ |=> txStrobe && txData == $past(regWrData))
    else $error("data write not handed to transmitter");
  a_tx_cause: assert property (txStrobe |-> $past(regWrite && regAddr == REG_DATA && enQ))
    else $error("transmit pulse without enabled data write");
  a_irq_raised: assert property (rxAvailable && ieQ |-> ##[0:1] uartIrq)
    else $error("interrupt missing with flag and enable");
  a_irq_cause: assert property (uartIrq |-> (rxAvailable || $past(rxAvailable)) && (ieQ || $past(ieQ)))
    else $error("interrupt without flag or enable");
  a_disable_clears: assert property (s_disable_wr |=> ##2 !rxAvailable && !rxOverrun)
    else $error("disable left status set");
  a_off_stays_quiet: assert property (!enQ [*3] |-> !rxAvailable)
    else $error("flag set while disabled");
  a_overrun_sticky: assert property (rxOverrun && enQ && !(regWrite && regAddr == REG_CONTROL) |=> rxOverrun)
    else $error("overrun dropped without disable");
endmodule : ubg_properties

bind ubg_top ubg_properties #(.RX_DEPTH(RX_DEPTH)) u_props (
  .clk_sys(clk_sys), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
  .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .rxLine(rxLine),
  .txData(txData), .txStrobe(txStrobe), .rxAvailable(rxAvailable), .uartIrq(uartIrq),
  .rxOverrun(rxOverrun)
);

/* File: ubg_serial_model.sv */
`timescale 1ns/1ps
module ubg_serial_model (
  // clock
  input  wire logic clk_sys,
  // serial line toward the receiver
  output logic      rxLine
);
  // line idles high between frames
  initial rxLine = 1'b1;

  // one frame, lsb first; gap gives idle cycles so the sender can be prompt or slow
  task automatic sendByte(input logic [7:0] b, input logic [15:0] div, input logic [2:0] frac,
                          input int gap);
    logic [10:0] frame; // start, eight data bits, two stop bits
    logic [3:0]  acc;   // fraction accumulator, wraps
    int          len;   // cycles of the current bit
    frame = {2'b11, b, 1'b0}; // two stop bits let the receiver resync
    acc = 4'h0;
    repeat (gap + 1) @(posedge clk_sys);
    for (int i = 0; i < 11; i++) begin
      len = int'(div) + int'(({1'b0, acc[2:0]} + {1'b0, frac}) > 4'h7); // carry adds a cycle
      acc = acc + {1'b0, frac};
      rxLine <= frame[i];
      repeat (len) @(posedge clk_sys);
    end
  endtask : sendByte
endmodule : ubg_serial_model

/* File: ubg_top_bench.sv */
`timescale 1ns/1ps
module ubg_top_bench;
  import ubg_pkg::*;
  localparam int TIMEOUT = 30000; // frames here need well under 10000 cycles
  logic        clk_sys;     // 40 MHz core clock
  logic        rst;         // async reset, active high
  logic [2:0]  regAddr;     // register index
  logic [7:0]  regWrData;   // write data
  logic        regWrite;    // write strobe
  logic        regRead;     // read strobe
  logic [7:0]  regRdData;   // read answer
  logic        rxLine;      // serial line from the far side
  logic [7:0]  txData;      // byte handed to the transmitter
  logic        txStrobe;    // hand-over pulse
  logic        rxAvailable; // receive flag
  logic        uartIrq;     // interrupt request
  logic        rxOverrun;   // overrun flag
  logic        want;        // expected flag level
  int          num_errors;  // mismatches
  int          compares;    // comparisons made
  int          cycles;      // hang guard
  // divisor corners: fast-range floor, fraction, high byte in use, fast range plain
  logic [15:0] divTab [4] = '{16'h0008, 16'h0011, 16'h0111, 16'h0010};
  logic [2:0]  fracTab [4] = '{3'h5, 3'h3, 3'h7, 3'h0};
  logic        rngTab [4] = '{1'b1, 1'b0, 1'b0, 1'b1};

  ubg_top u_dut (
    .clk_sys(clk_sys), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .rxLine(rxLine),
    .txData(txData), .txStrobe(txStrobe), .rxAvailable(rxAvailable), .uartIrq(uartIrq),
    .rxOverrun(rxOverrun)
  );
  ubg_serial_model u_far (.clk_sys(clk_sys), .rxLine(rxLine));

  // free-running clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // one comparison, x never matches
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one-cycle write strobe
  task automatic regWr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regAddr   <= a;
    regWrData <= d;
    regWrite  <= 1'b1;
    @(posedge clk_sys);
    regWrite  <= 1'b0;
  endtask : regWr

  // one-cycle read strobe, answer looked at in the following cycle only
  task automatic regRd(input logic [2:0] a, input logic [7:0] exp, input string what);
    @(posedge clk_sys);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1;
    check(what, regRdData, exp);
  endtask : regRd

  // low byte before high byte, then the fifo control
  task automatic setBaud(input logic [15:0] div, input logic [2:0] frac, input logic rng,
                         input logic [1:0] thr);
    regWr(REG_DIV_LOW, div[7:0]);
    regWr(REG_DIV_HIGH, div[15:8]);
    regWr(REG_FIFO_CTL, {2'h0, frac, rng, thr});
  endtask : setBaud

  // far side sends a byte; it lands two cycles after its stop bit
  task automatic recv(input logic [7:0] b, input logic [15:0] div, input logic [2:0] frac,
                      input int gap);
    u_far.sendByte(b, div, frac, gap);
    repeat (4) @(posedge clk_sys);
  endtask : recv

  // verdict and end of run
  task automatic final_report;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report

  // hang guard counts as a mismatch
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == TIMEOUT) begin
      num_errors++;
      final_report();
    end
  end

  // main sequence
  initial begin
    rst = 1'b1;
    regAddr = 3'h0;
    regWrData = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
    num_errors = 0;
    compares = 0;
    cycles = 0;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    // reset values, then an unmapped index
    for (int a = 1; a < 5; a++) regRd(3'(a), 8'h00, "reset value");
    regRd(3'h7, 8'h00, "unmapped");
    regRd(REG_STATUS, 8'h08, "status after reset");
    regWr(REG_FIFO_CTL, 8'hff);
    regRd(REG_FIFO_CTL, 8'h3f, "ctl upper bits");
    regWr(REG_FILL_CNT, 8'hff);
    regRd(REG_FILL_CNT, 8'h00, "count is read-only");
    // a data write is handed on while enabled
    regWr(REG_CONTROL, 8'h03);
    regRd(REG_CONTROL, 8'h03, "control readback");
    regWr(REG_DATA, 8'ha5);
    #1;
    check("tx strobe", {7'h0, txStrobe}, 8'h01);
    check("tx data", txData, 8'ha5);
    // every threshold code against fills of one to four, sender prompt to slow
    for (int c = 0; c < 4; c++) begin
      regWr(REG_CONTROL, 8'h00);
      setBaud(16'h0010, 3'h0, 1'b0, 2'(c));
      regWr(REG_CONTROL, 8'h03);
      for (int k = 1; k < 5; k++) begin
        recv(8'h30 + 8'(k), 16'h0010, 3'h0, 8 * k);
        want = (c == 0) ? (k == 4) : (k >= c);
        regRd(REG_FILL_CNT, 8'(k), "fill count");
        check("available", {7'h0, rxAvailable}, {7'h0, want});
        check("irq", {7'h0, uartIrq}, {7'h0, want});
      end
    end
    // full queue: fifth byte waits, sixth replaces it
    recv(8'h5a, 16'h0010, 3'h0, 0);
    recv(8'hc3, 16'h0010, 3'h0, 0);
    regRd(REG_FILL_CNT, 8'h04, "count full");
    check("overrun", {7'h0, rxOverrun}, 8'h01);
    regRd(REG_STATUS, 8'h07, "status full");
    for (int k = 1; k < 5; k++) regRd(REG_DATA, 8'h30 + 8'(k), "queued byte");
    regRd(REG_DATA, 8'hc3, "held byte");
    regRd(REG_FILL_CNT, 8'h00, "count drained");
    // disable flushes status but keeps the settings
    regWr(REG_CONTROL, 8'h00);
    regWr(REG_DATA, 8'h77);
    #1;
    check("tx while off", {7'h0, txStrobe}, 8'h00);
    check("overrun off", {7'h0, rxOverrun}, 8'h00);
    regRd(REG_FIFO_CTL, 8'h03, "ctl kept");
    regRd(REG_DIV_LOW, 8'h10, "divisor kept");
    // fractions, fast range floor and a divisor using its high byte, irq masked
    regWr(REG_CONTROL, 8'h01);
    for (int i = 0; i < 4; i++) begin
      setBaud(divTab[i], fracTab[i], rngTab[i], 2'h1); // only between frames
      recv(8'h96 ^ 8'(i * 37), divTab[i], fracTab[i], 3);
      check("irq masked", {7'h0, uartIrq}, 8'h00);
      regRd(REG_DATA, 8'h96 ^ 8'(i * 37), "baud case");
    end
    final_report();
  end
endmodule : ubg_top_bench
